/* File: inc/ffm_pkg.sv */
// shared constants for the fault flag and mask register pair
package ffm_pkg;
    // register word width and address width of the register port
    localparam int REG_W = 16;
    localparam int ADDR_W = 7;
    // register offsets
    localparam logic [ADDR_W-1:0] FLAGS_ADDR = 7'h06;
    localparam logic [ADDR_W-1:0] MASK_ADDR = 7'h07;
    // reset values
    localparam logic [REG_W-1:0] FLAGS_RESET = 16'h0000;
    localparam logic [REG_W-1:0] MASK_RESET = 16'h0040;
    // fault flag bit positions
    localparam int ROM_SUM_BIT = 0;
    localparam int MAP_SUM_BIT = 1;
    localparam int LINK_SUM_BIT = 2;
    localparam int BAD_WRITE_BIT = 3;
    localparam int BAD_READ_BIT = 4;
    localparam int EXT_LO_BIT = 5;
    localparam int EXT_HI_BIT = 11;
    // mask register fields
    localparam int TICK_ON_BIT = 12;
    localparam int POS_RANGE_BIT = 11;
    localparam int NEG_RANGE_BIT = 10;
    localparam int MASK_FLAG_HI = 11;
    localparam int RSVD_LO = 13;
    // writable bits of the mask, flags that exist in the flag register
    localparam logic [REG_W-1:0] MASK_RW_BITS = 16'h1fff;
    localparam logic [REG_W-1:0] FLAG_BITS = 16'h0fff;
    // checksum engine constants
    localparam logic [REG_W-1:0] SUM_POLY = 16'h1021;
    localparam logic [REG_W-1:0] SUM_SEED = 16'hffff;
    // map checker states
    typedef enum logic [2:0] {
        MC_OFF = 3'b001,
        MC_SWEEP = 3'b010,
        MC_CHECK = 3'b100
    } ffm_map_state_t;
    // power-up rom check states
    typedef enum logic [2:0] {
        RB_START = 3'b001,
        RB_WAIT = 3'b010,
        RB_DONE = 3'b100
    } ffm_rom_state_t;
endpackage

/* File: design/ffm_crc_sweep.sv */
// checksum engine that walks a word array by index and reports its crc
`timescale 1ns/100ps
`default_nettype none
module ffm_crc_sweep #(
    parameter int WORDS = 8,
    parameter int IDX_W = 3
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic start_in,
    input wire logic [ffm_pkg::REG_W-1:0] word_in,
    output logic [IDX_W-1:0] index_out,
    output logic busy_out,
    output logic done_out,
    output logic [ffm_pkg::REG_W-1:0] sum_out
);
    import ffm_pkg::*;

    logic busy_q, busy_d, done_q, done_d;
    logic [IDX_W-1:0] idx_q, idx_d;
    logic [REG_W-1:0] crc_q, crc_d, sum_q, sum_d, crc_step;

    // one word folded into the running crc, msb first
    always_comb
    begin
        crc_step = crc_q;
        for (int i = REG_W - 1; i >= 0; i--)
        begin
            crc_step = {crc_step[REG_W-2:0], 1'b0} ^ ((crc_step[REG_W-1] ^ word_in[i]) ? SUM_POLY : '0);
        end
    end

    // sweep control: one word per clock, a start while busy is ignored
    always_comb
    begin
        busy_d = busy_q;
        idx_d = idx_q;
        crc_d = crc_q;
        sum_d = sum_q;
        done_d = 1'b0;
        if (!busy_q && start_in)
        begin
            busy_d = 1'b1;
            idx_d = '0;
            crc_d = SUM_SEED;
        end
        else if (busy_q)
        begin
            crc_d = crc_step;
            idx_d = idx_q + 1'b1;
            if (idx_q == IDX_W'(WORDS - 1))
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
                sum_d = crc_step;
                idx_d = '0;
            end
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            idx_q <= '0;
            crc_q <= SUM_SEED;
            sum_q <= '0;
        end
        else
        begin
            busy_q <= busy_d;
            done_q <= done_d;
            idx_q <= idx_d;
            crc_q <= crc_d;
            sum_q <= sum_d;
        end
    end

    assign index_out = idx_q;
    assign busy_out = busy_q;
    assign done_out = done_q;
    assign sum_out = sum_q;
endmodule
`default_nettype wire

/* File: design/ffm_fault_regs.sv */
// sticky fault flag register, its mask register and the checksum monitors
`timescale 1ns/100ps
`default_nettype none
module ffm_fault_regs #(
    parameter int MAP_WORDS = 8,
    parameter int MAP_IDX_W = 3,
    parameter int ROM_WORDS = 16,
    parameter int ROM_IDX_W = 4,
    parameter logic [15:0] ROM_SUM_REF = 16'h0000
) (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [ffm_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_addr_valid_in,
    input wire logic [ffm_pkg::REG_W-1:0] reg_wdata_in,
    output logic [ffm_pkg::REG_W-1:0] reg_rdata_out,
    input wire logic link_sum_fail_in,
    input wire logic [ffm_pkg::EXT_HI_BIT:ffm_pkg::EXT_LO_BIT] ext_fault_in,
    input wire logic map_write_in,
    input wire logic [ffm_pkg::REG_W-1:0] map_word_in,
    output logic [MAP_IDX_W-1:0] map_index_out,
    input wire logic [ffm_pkg::REG_W-1:0] rom_word_in,
    output logic [ROM_IDX_W-1:0] rom_index_out,
    output logic rom_check_done_out,
    output logic master_tick_counter_on_out,
    output logic pos_input_range_fault_on_out,
    output logic neg_input_range_fault_on_out,
    output logic [ffm_pkg::REG_W-1:0] fault_flags_out,
    output logic fault_any_out
);
    import ffm_pkg::*;

    logic [REG_W-1:0] flags_q, flags_d, mask_q, mask_d, rdata_q, rdata_d;
    logic [REG_W-1:0] events, set_bits, clr_bits;
    logic wr_flags, wr_mask, rd_flags, rd_mask;
    logic bad_wr, bad_rd;
    ffm_map_state_t mc_q, mc_d;
    ffm_rom_state_t rb_q, rb_d;
    logic [REG_W-1:0] map_ref_q, map_ref_d;
    logic map_ref_ok_q, map_ref_ok_d, dirty_q, dirty_d;
    logic map_start, map_busy, map_done, map_mismatch;
    logic [REG_W-1:0] map_sum, rom_sum;
    logic rom_start, rom_done, rom_mismatch;
    logic host_touch, map_on;

    // address decode of the register port
    assign wr_flags = reg_wr_in && reg_addr_valid_in && (reg_addr_in == FLAGS_ADDR);
    assign wr_mask = reg_wr_in && reg_addr_valid_in && (reg_addr_in == MASK_ADDR);
    assign rd_flags = reg_rd_in && reg_addr_valid_in && (reg_addr_in == FLAGS_ADDR);
    assign rd_mask = reg_rd_in && reg_addr_valid_in && (reg_addr_in == MASK_ADDR);
    assign bad_wr = reg_wr_in && !reg_addr_valid_in;
    assign bad_rd = reg_rd_in && !reg_addr_valid_in;
    assign map_on = mask_q[MAP_SUM_BIT];
    // any host write, to the map or to these registers, spoils the current sweep
    assign host_touch = map_write_in || wr_mask || wr_flags;

    // raw detection events at their flag positions
    always_comb
    begin
        events = '0;
        events[ROM_SUM_BIT] = rom_mismatch;
        events[MAP_SUM_BIT] = map_mismatch;
        events[LINK_SUM_BIT] = link_sum_fail_in;
        events[BAD_WRITE_BIT] = bad_wr;
        events[BAD_READ_BIT] = bad_rd;
        events[EXT_HI_BIT:EXT_LO_BIT] = ext_fault_in;
    end

    // a flag only sets while its enable is on; sets beat clears, zeros do nothing
    always_comb
    begin
        set_bits = events & mask_q & FLAG_BITS;
        clr_bits = wr_flags ? (reg_wdata_in & FLAG_BITS) : '0;
        flags_d = (flags_q & ~clr_bits) | set_bits;
    end

    // mask register: reserved bits never take a write
    always_comb
    begin
        mask_d = mask_q;
        if (wr_mask)
        begin
            mask_d = reg_wdata_in & MASK_RW_BITS;
        end
    end

    // read data is captured on the read strobe and held until the next read
    always_comb
    begin
        rdata_d = rdata_q;
        if (reg_rd_in)
        begin
            rdata_d = rd_flags ? flags_q : (rd_mask ? mask_q : '0);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            flags_q <= FLAGS_RESET;
            mask_q <= MASK_RESET;
            rdata_q <= '0;
        end
        else
        begin
            flags_q <= flags_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // background map checker: first clean pass sets the reference; a pass disturbed by a host
    // write may mix old and new words, so it only forgets the reference instead of flagging
    always_comb
    begin
        mc_d = mc_q;
        map_ref_d = map_ref_q;
        map_ref_ok_d = map_ref_ok_q;
        dirty_d = dirty_q || host_touch;
        map_start = 1'b0;
        map_mismatch = 1'b0;
        unique case (mc_q)
            MC_OFF:
            begin
                map_ref_ok_d = 1'b0;
                dirty_d = 1'b0;
                if (map_on)
                begin
                    mc_d = MC_SWEEP;
                end
            end
            MC_SWEEP:
            begin
                map_start = !map_busy && !map_done;
                if (map_done)
                begin
                    mc_d = MC_CHECK;
                end
            end
            MC_CHECK:
            begin
                if (dirty_q || host_touch)
                begin
                    map_ref_ok_d = 1'b0;
                end
                else if (!map_ref_ok_q)
                begin
                    map_ref_d = map_sum;
                    map_ref_ok_d = 1'b1;
                end
                else
                begin
                    map_mismatch = (map_sum != map_ref_q);
                end
                dirty_d = 1'b0;
                mc_d = map_on ? MC_SWEEP : MC_OFF;
            end
            default:
            begin
                mc_d = MC_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            mc_q <= MC_OFF;
            map_ref_q <= '0;
            map_ref_ok_q <= 1'b0;
            dirty_q <= 1'b0;
        end
        else
        begin
            mc_q <= mc_d;
            map_ref_q <= map_ref_d;
            map_ref_ok_q <= map_ref_ok_d;
            dirty_q <= dirty_d;
        end
    end

    // one rom sweep after every reset; the result is judged once
    always_comb
    begin
        rb_d = rb_q;
        rom_start = 1'b0;
        rom_mismatch = 1'b0;
        unique case (rb_q)
            RB_START:
            begin
                rom_start = 1'b1;
                rb_d = RB_WAIT;
            end
            RB_WAIT:
            begin
                if (rom_done)
                begin
                    rom_mismatch = (rom_sum != ROM_SUM_REF);
                    rb_d = RB_DONE;
                end
            end
            RB_DONE:
            begin
                rb_d = RB_DONE;
            end
            default:
            begin
                rb_d = RB_DONE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            rb_q <= RB_START;
        end
        else
        begin
            rb_q <= rb_d;
        end
    end

    ffm_crc_sweep #(
        .WORDS(MAP_WORDS),
        .IDX_W(MAP_IDX_W)
    ) u_map_sweep (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .start_in(map_start),
        .word_in(map_word_in),
        .index_out(map_index_out),
        .busy_out(map_busy),
        .done_out(map_done),
        .sum_out(map_sum)
    );

    ffm_crc_sweep #(
        .WORDS(ROM_WORDS),
        .IDX_W(ROM_IDX_W)
    ) u_rom_sweep (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .start_in(rom_start),
        .word_in(rom_word_in),
        .index_out(rom_index_out),
        .busy_out(),
        .done_out(rom_done),
        .sum_out(rom_sum)
    );

    // outputs; enables come straight from mask flip-flops
    assign reg_rdata_out = rdata_q;
    assign fault_flags_out = flags_q;
    assign fault_any_out = |(flags_q & mask_q & FLAG_BITS);
    assign master_tick_counter_on_out = mask_q[TICK_ON_BIT];
    assign pos_input_range_fault_on_out = mask_q[POS_RANGE_BIT];
    assign neg_input_range_fault_on_out = mask_q[NEG_RANGE_BIT];
    assign rom_check_done_out = (rb_q == RB_DONE);

    // longest wait from the rom sweep start to its verdict
    localparam int ROM_DONE_MAX = ROM_WORDS + 2;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_bad_write;
        reg_wr_in && !reg_addr_valid_in && mask_q[BAD_WRITE_BIT];
    endsequence

    sequence s_bad_read;
        reg_rd_in && !reg_addr_valid_in && mask_q[BAD_READ_BIT];
    endsequence

    a_bad_write_flag: assert property (s_bad_write |=> flags_q[BAD_WRITE_BIT])
        else $error("invalid-address write did not set flag 3");
    a_bad_read_flag: assert property (s_bad_read |=> flags_q[BAD_READ_BIT])
        else $error("invalid-address read did not set flag 4");
    a_link_sum_flag: assert property (link_sum_fail_in && mask_q[LINK_SUM_BIT] ##1 !wr_flags
        |-> ##1 flags_q[LINK_SUM_BIT])
        else $error("link checksum flag lost before a clear");
    a_set_beats_clr: assert property (wr_flags && reg_wdata_in[LINK_SUM_BIT] && link_sum_fail_in
        && mask_q[LINK_SUM_BIT] |=> flags_q[LINK_SUM_BIT])
        else $error("clear won over a coincident set");
    a_zero_keeps: assert property (wr_flags && !set_bits[BAD_WRITE_BIT] |=>
        flags_q[BAD_WRITE_BIT] == ($past(flags_q[BAD_WRITE_BIT]) && !$past(reg_wdata_in[BAD_WRITE_BIT])))
        else $error("flag write did not act as write-one-to-clear");
    a_masked_quiet: assert property (!mask_q[BAD_READ_BIT] && !flags_q[BAD_READ_BIT] |=>
        !flags_q[BAD_READ_BIT])
        else $error("disabled flag became set");
    a_rsvd_zero: assert property (mask_q[REG_W-1:RSVD_LO] == '0)
        else $error("reserved mask bits not zero");
    a_mask_write: assert property (wr_mask |=> mask_q == ($past(reg_wdata_in) & MASK_RW_BITS))
        else $error("mask register did not take the write");
    a_tick_follow: assert property (wr_mask ##1 1'b1 |-> master_tick_counter_on_out
        == $past(reg_wdata_in[TICK_ON_BIT]))
        else $error("tick counter enable does not follow mask bit 12");
    a_touch_no_flag: assert property (mc_q == MC_CHECK && (dirty_q || host_touch) |-> !map_mismatch)
        else $error("map flag raised on a pass with a host write");
    a_map_runs: assert property (mc_q == MC_OFF && map_on |=> ##[1:2] map_busy)
        else $error("map checker did not start while enabled");
    a_rom_once: assert property (rb_q == RB_WAIT |-> ##[1:ROM_DONE_MAX] rb_q == RB_DONE)
        else $error("power-up rom check did not finish");
endmodule
`default_nettype wire

/* File: testbench/ffm_host_model.sv */
// far side model: configuration map and rom that answer by index, with a poke port for upsets
`timescale 1ns/100ps
`default_nettype none
module ffm_host_model (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [2:0] map_index_in,
    input wire logic [3:0] rom_index_in,
    input wire logic poke_in,
    input wire logic [2:0] poke_index_in,
    input wire logic [15:0] poke_value_in,
    output logic [15:0] map_word_out,
    output logic [15:0] rom_word_out
);
    import ffm_pkg::*;
    logic [15:0] map_q [8];
    // the poke port changes a map word; the bench decides whether a host write goes with it
    always_ff @(posedge ref_clk_in)
    begin
        if (!resetn_in)
        begin
            for (int i = 0; i < 8; i++)
                map_q[i] <= 16'h0100 * 16'(i) + 16'h0033;
        end
        else if (poke_in)
            map_q[poke_index_in] <= poke_value_in;
    end
    // combinational lookups, same cycle as the index
    assign map_word_out = map_q[map_index_in];
    assign rom_word_out = 16'ha5c3 + 16'(rom_index_in) * 16'h0111;
endmodule
`default_nettype wire

/* File: testbench/ffm_fault_regs_tb.sv */
// self-checking bench for the fault flag and mask register pair
`timescale 1ns/100ps
`default_nettype none
module ffm_fault_regs_tb;
    import ffm_pkg::*;
    // rom reference handed to the design; the model's image does not match it, so flag 0 is expected
    localparam logic [15:0] ROM_SUM_REF = 16'h0000;
    typedef struct packed {logic [15:0] wdata; logic [15:0] rdata;} ffm_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [6:0] addr = 7'h00;
    logic valid = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic link = 1'b0;
    logic [11:5] ext = 7'h00;
    logic map_wr = 1'b0;
    logic poke = 1'b0;
    logic [2:0] poke_idx = 3'h0;
    logic [15:0] poke_val = 16'h0000;
    logic [15:0] rdata, map_word, rom_word, flags, rd_val;
    logic [2:0] map_idx;
    logic [3:0] rom_idx;
    logic rom_done, tick_on, pos_on, neg_on, any;
    int n_errors = 0;
    int n_tests = 0;
    // mask writes, some setting reserved bits: data written, value read back
    ffm_row_t rows [6] = '{'{16'hffff, 16'h1fff}, '{16'h0000, 16'h0000}, '{16'h1002, 16'h1002},
                          '{16'h0800, 16'h0800}, '{16'h0400, 16'h0400}, '{16'he0f7, 16'h00f7}};
    always #4 clk = ~clk;
    ffm_fault_regs #(.ROM_SUM_REF(ROM_SUM_REF)) u_ffm_fault_regs (.ref_clk_in(clk), .resetn_in(rstn), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_addr_in(addr), .reg_addr_valid_in(valid), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .link_sum_fail_in(link), .ext_fault_in(ext), .map_write_in(map_wr),
        .map_word_in(map_word), .map_index_out(map_idx), .rom_word_in(rom_word), .rom_index_out(rom_idx),
        .rom_check_done_out(rom_done), .master_tick_counter_on_out(tick_on),
        .pos_input_range_fault_on_out(pos_on), .neg_input_range_fault_on_out(neg_on),
        .fault_flags_out(flags), .fault_any_out(any));
    ffm_host_model u_ffm_host_model (.ref_clk_in(clk), .resetn_in(rstn), .map_index_in(map_idx),
        .rom_index_in(rom_idx), .poke_in(poke), .poke_index_in(poke_idx), .poke_value_in(poke_val),
        .map_word_out(map_word), .rom_word_out(rom_word));
    // compare a register-wide value
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    // compare a single status bit
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
        end
    endtask
    // one strobe, held over one sampling edge; results are settled 1 ns later
    task automatic reg_op(input logic wr, input logic [6:0] a, input logic v, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= ~wr;
        addr <= a;
        valid <= v;
        wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rd_val = rdata;
    endtask
    // one-cycle event pulses on the fault inputs
    task automatic pulse(input logic [11:5] e, input logic l);
        @(posedge clk);
        ext <= e;
        link <= l;
        @(posedge clk);
        ext <= 7'h00;
        link <= 1'b0;
        #1;
    endtask
    // change one map word, with or without the host write indication
    task automatic upset(input logic with_write, input logic [15:0] v);
        @(posedge clk);
        poke <= 1'b1;
        poke_idx <= 3'h5;
        poke_val <= v;
        map_wr <= with_write;
        @(posedge clk);
        poke <= 1'b0;
        map_wr <= 1'b0;
        repeat (60) @(posedge clk);
        #1;
    endtask
    // independent crc over the model's rom image, msb first
    function automatic logic [15:0] rom_crc();
        logic [15:0] c;
        logic [15:0] w;
        logic fb;
        c = SUM_SEED;
        for (int i = 0; i < 16; i++)
        begin
            w = 16'ha5c3 + 16'(i) * 16'h0111;
            for (int b = 15; b >= 0; b--)
            begin
                fb = c[15] ^ w[b];
                c = {c[14:0], 1'b0};
                if (fb)
                    c = c ^ SUM_POLY;
            end
        end
        return c;
    endfunction
    // single exit point with the verdict
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk_word(flags, 16'h0000, "flags after reset");
        chk_bit(tick_on, 1'b0, "tick enable after reset");
        chk_bit(pos_on | neg_on, 1'b0, "range enables after reset");
        reg_op(1'b0, MASK_ADDR, 1'b1, 16'h0000);
        chk_word(rd_val, 16'h0040, "mask after reset");
        // enable rom flag before the power-up sweep ends so a mismatch is reported
        reg_op(1'b1, MASK_ADDR, 1'b1, 16'h0001);
        for (int i = 0; i <= 100 && rom_done !== 1'b1; i++)
        begin
            if (i == 100)
            begin
                n_errors++;
                $display("wrong value at %0t: rom check never finished", $time);
                summarize();
            end
            @(posedge clk);
            #1;
        end
        repeat (2) @(posedge clk);
        #1;
        chk_word(flags, {15'h0000, rom_crc() != ROM_SUM_REF}, "rom checksum flag");
        reg_op(1'b1, FLAGS_ADDR, 1'b1, 16'hffff);
        chk_word(flags, 16'h0000, "flags cleared by ones");
        // mask writes and readback through the table
        foreach (rows[i])
        begin
            reg_op(1'b1, MASK_ADDR, 1'b1, rows[i].wdata);
            reg_op(1'b0, MASK_ADDR, 1'b1, 16'h0000);
            chk_word(rd_val, rows[i].rdata, "mask readback");
            chk_bit(tick_on, rows[i].rdata[12], "tick enable");
            chk_bit(pos_on, rows[i].rdata[11], "pos range enable");
            chk_bit(neg_on, rows[i].rdata[10], "neg range enable");
        end
        // mask is 0x00f7 now: bit 3 off, bit 4 on
        reg_op(1'b1, 7'h55, 1'b0, 16'h1234);
        chk_word(flags, 16'h0000, "masked bad write");
        chk_bit(any, 1'b0, "no fault reported");
        reg_op(1'b0, 7'h56, 1'b0, 16'h0000);
        chk_word(rd_val, 16'h0000, "bad read data");
        chk_word(flags, 16'h0010, "bad read flag");
        chk_bit(any, 1'b1, "fault reported");
        reg_op(1'b1, MASK_ADDR, 1'b1, 16'h1fff);
        reg_op(1'b1, 7'h55, 1'b0, 16'h1234);
        chk_word(flags, 16'h0018, "bad write flag");
        reg_op(1'b1, FLAGS_ADDR, 1'b1, 16'h0000);
        chk_word(flags, 16'h0018, "zero write keeps flags");
        reg_op(1'b1, FLAGS_ADDR, 1'b1, 16'h0008);
        chk_word(flags, 16'h0010, "clear one flag only");
        reg_op(1'b1, FLAGS_ADDR, 1'b1, 16'h0010);
        pulse(7'h00, 1'b1);
        chk_word(flags, 16'h0004, "link checksum flag");
        // event and clear meet at one edge: the flag must stay
        @(posedge clk);
        link <= 1'b1;
        reg_wr <= 1'b1;
        addr <= FLAGS_ADDR;
        valid <= 1'b1;
        wdata <= 16'h0004;
        @(posedge clk);
        link <= 1'b0;
        reg_wr <= 1'b0;
        #1;
        chk_word(flags, 16'h0004, "set beats clear");
        reg_op(1'b1, FLAGS_ADDR, 1'b1, 16'h0004);
        pulse(7'h40, 1'b0);
        chk_word(flags, 16'h0800, "pos range flag");
        reg_op(1'b1, MASK_ADDR, 1'b1, 16'h1bff);
        pulse(7'h20, 1'b0);
        chk_word(flags, 16'h0800, "neg range masked");
        reg_op(1'b1, FLAGS_ADDR, 1'b1, 16'h0800);
        // map checker runs with bit 1 set; a legal write must never flag
        repeat (60) @(posedge clk);
        #1;
        chk_word(flags, 16'h0000, "stable map");
        upset(1'b1, 16'h7777);
        chk_word(flags, 16'h0000, "written map change");
        upset(1'b0, 16'h0bad);
        chk_word(flags, 16'h0002, "silent map change");
        summarize();
    end
endmodule
`default_nettype wire
